// ---- rcm_pkg.sv ----
// constants for the temperature rate-of-change monitor
package rcm_pkg;
	localparam logic [7:0] RCM_ADDR_GAIN = 8'h3D;
	localparam logic [7:0] RCM_ADDR_CONFIG = 8'h3E;
	localparam logic [7:0] RCM_ADDR_STATUS = 8'h3F;
	localparam logic [7:0] RCM_ADDR_RES1H = 8'h40;
	localparam logic [7:0] RCM_ADDR_LIM1H = 8'h41;
	localparam logic [7:0] RCM_ADDR_LIM1L = 8'h42;
	localparam logic [7:0] RCM_ADDR_SMP1 = 8'h43;
	localparam logic [7:0] RCM_ADDR_RES2H = 8'h44;
	localparam logic [7:0] RCM_ADDR_RESL = 8'h45;
	localparam logic [7:0] RCM_ADDR_LIM2H = 8'h46;
	localparam logic [7:0] RCM_ADDR_LIM2L = 8'h47;
	localparam logic [7:0] RCM_ADDR_SMP2 = 8'h48;
	localparam logic [7:0] RCM_RESET_BYTE = 8'h00;
	localparam int RCM_GAIN1_LSB = 0;
	localparam int RCM_GAIN2_LSB = 3;
	localparam int RCM_CFG_EN = 5;
	localparam int RCM_CFG_MASK2 = 4;
	localparam int RCM_CFG_CHAN1_RATE_ALERT_MASK = 3;
	localparam logic [7:0] RCM_CFG_WMASK = 8'h3F;
	localparam logic [7:0] RCM_LIML_WMASK = 8'hF0;
	localparam logic [3:0] RCM_SMP_MAXCODE = 4'h8;
	localparam logic [8:0] RCM_SMP_MAX = 9'h101;
	// hysteresis in 0.125 degC steps
	localparam logic [11:0] RCM_HYST [8] = '{12'h000, 12'h001, 12'h002, 12'h004,
		12'h008, 12'h010, 12'h018, 12'h020};
	localparam logic [1:0] RCM_DIR_NONE = 2'h0;
	localparam logic [1:0] RCM_DIR_UP = 2'h1;
	localparam logic [1:0] RCM_DIR_DOWN = 2'h2;
	localparam logic [19:0] RCM_SAT_POS = 20'h0_07FF;
	localparam logic [19:0] RCM_SAT_NEG = 20'hF_F800;
	typedef logic [11:0] rcm_rate_t;
endpackage

// ---- rcm_top.sv ----
// rate-of-change monitor for two remote temperature channels
// How it works
// - channel 2 gain is two to code
// - channel 1 gain, same power-of-two code
// - calculation runs only while enable set
// - mask bit blocks channel 2 alert
// - mask bit blocks channel 1 alert
// - reversal counts only beyond hysteresis setting
// - slope changed bits per channel
// - odd reversal count bits per channel
// - high flags set over non-negative limit, read-clear
// - low flags on negative limit, read-clear
// - upper result bytes at 40h, 44h
// - lower result nibbles packed at 45h
// - high limits at 41h, 46h drive alert
// - index one and two select channels
// - low limit nibble extends each limit
// - sample count code sets window length
`timescale 1ns/100ps
`default_nettype none
module rcm_top
	import rcm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic temp_valid,
	input wire logic temp_chan,
	input wire logic [10:0] temp_value,
	output logic rate_alert
);
	import rcm_pkg::*;

	logic [7:0] gain_reg;
	logic [7:0] config_reg;
	logic [7:0] rdata_reg;
	logic [1:0] hi_reg;
	logic [1:0] lo_reg;
	logic [7:0] limh_reg [2];
	logic [7:0] liml_reg [2];
	logic [3:0] smp_reg [2];
	wire [1:0][11:0] res_w;
	wire [1:0] done_w;
	wire [1:0] chg_w;
	wire [1:0] odd_w;
	wire [1:0] hi_set;
	wire [1:0] lo_set;
	wire [1:0][11:0] lim_w;
	wire enable = config_reg[RCM_CFG_EN];
	wire [11:0] hyst = RCM_HYST[config_reg[2:0]];
	wire wr_gain = reg_wr & (reg_addr == RCM_ADDR_GAIN);
	wire wr_cfg = reg_wr & (reg_addr == RCM_ADDR_CONFIG);
	wire rd_stat = reg_rd & (reg_addr == RCM_ADDR_STATUS);
	// channel index 1 and 2 select the register pairs
	// per-channel index
	wire [1:0] wr_limh = {reg_wr & (reg_addr == RCM_ADDR_LIM2H), reg_wr & (reg_addr == RCM_ADDR_LIM1H)};
	wire [1:0] wr_liml = {reg_wr & (reg_addr == RCM_ADDR_LIM2L), reg_wr & (reg_addr == RCM_ADDR_LIM1L)};
	wire [1:0] wr_smp = {reg_wr & (reg_addr == RCM_ADDR_SMP2), reg_wr & (reg_addr == RCM_ADDR_SMP1)};
	wire [7:0] status_w = {chg_w[1], chg_w[0], odd_w[1], odd_w[0], hi_reg[1], hi_reg[0], lo_reg[1], lo_reg[0]};
	wire [7:0] rd_mux =
		(reg_addr == RCM_ADDR_GAIN) ? gain_reg :
		(reg_addr == RCM_ADDR_CONFIG) ? config_reg :
		(reg_addr == RCM_ADDR_STATUS) ? status_w :
		(reg_addr == RCM_ADDR_RES1H) ? res_w[0][11:4] :
		(reg_addr == RCM_ADDR_RES2H) ? res_w[1][11:4] :
		(reg_addr == RCM_ADDR_RESL) ? {res_w[1][3:0], res_w[0][3:0]} :
		(reg_addr == RCM_ADDR_LIM1H) ? limh_reg[0] :
		(reg_addr == RCM_ADDR_LIM2H) ? limh_reg[1] :
		(reg_addr == RCM_ADDR_LIM1L) ? liml_reg[0] :
		(reg_addr == RCM_ADDR_LIM2L) ? liml_reg[1] :
		(reg_addr == RCM_ADDR_SMP1) ? {4'h0, smp_reg[0]} :
		(reg_addr == RCM_ADDR_SMP2) ? {4'h0, smp_reg[1]} : RCM_RESET_BYTE;

	assign reg_rdata = rdata_reg;
	assign rate_alert = (|{hi_reg[1], lo_reg[1]} & ~config_reg[RCM_CFG_MASK2]) |
		(|{hi_reg[0], lo_reg[0]} & ~config_reg[RCM_CFG_CHAN1_RATE_ALERT_MASK]);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			gain_reg <= RCM_RESET_BYTE;
			config_reg <= RCM_RESET_BYTE;
			rdata_reg <= RCM_RESET_BYTE;
		end
		else
		begin
			if (wr_gain)
				gain_reg <= reg_wdata;
			if (wr_cfg)
				config_reg <= reg_wdata & RCM_CFG_WMASK;
			if (reg_rd)
				rdata_reg <= rd_mux;
		end
	end

	// high flags, set wins over read-clear
	// low flags, set wins over read-clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			hi_reg <= '0;
			lo_reg <= '0;
		end
		else
		begin
			hi_reg <= (rd_stat ? 2'h0 : hi_reg) | hi_set;
			lo_reg <= (rd_stat ? 2'h0 : lo_reg) | lo_set;
		end
	end

	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_chan
			logic [8:0] cnt_reg;
			logic [11:0] first_reg;
			logic [11:0] ext_reg;
			logic [1:0] dir_reg;
			logic par_reg;
			logic chg_reg;
			logic shown_chg_reg;
			logic shown_odd_reg;
			rcm_rate_t res_reg;
			logic [2:0] gcode;
			logic [8:0] n_smp;
			logic [11:0] ts;
			logic [11:0] diff;
			logic [19:0] scaled;
			rcm_rate_t sat;
			logic rise;
			logic fall;
			logic rev;
			logic hit;

			assign gcode = (c == 0) ? gain_reg[RCM_GAIN1_LSB +: 3] : gain_reg[RCM_GAIN2_LSB +: 3];
			assign n_smp = (smp_reg[c] >= RCM_SMP_MAXCODE) ? RCM_SMP_MAX :
				9'((9'h001 << smp_reg[c][2:0]) + 9'h001);
			assign hit = enable & temp_valid & (temp_chan == 1'(c));
			assign ts = {temp_value[10], temp_value};
			assign rise = $signed(ts) > $signed(12'(ext_reg + hyst));
			assign fall = $signed(ts) < $signed(12'(ext_reg - hyst));
			assign rev = ((dir_reg == RCM_DIR_UP) & fall) | ((dir_reg == RCM_DIR_DOWN) & rise);
			assign diff = 12'(ts - first_reg);
			assign scaled = 20'($signed({{8{diff[11]}}, diff}) <<< gcode);
			assign sat = ($signed(scaled) > $signed(RCM_SAT_POS)) ? RCM_SAT_POS[11:0] :
				($signed(scaled) < $signed(RCM_SAT_NEG)) ? RCM_SAT_NEG[11:0] : scaled[11:0];
			assign done_w[c] = hit & (cnt_reg != 9'h000) & (9'(cnt_reg + 9'h001) == n_smp);
			assign res_w[c] = res_reg;
			assign chg_w[c] = shown_chg_reg;
			assign odd_w[c] = shown_odd_reg;
			assign lim_w[c] = {limh_reg[c], liml_reg[c][7:4]};
			assign hi_set[c] = done_w[c] & ~lim_w[c][11] & ($signed(sat) > $signed(lim_w[c]));
			assign lo_set[c] = done_w[c] & lim_w[c][11] & ($signed(sat) < $signed(lim_w[c]));

			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
				begin
					limh_reg[c] <= RCM_RESET_BYTE;
					liml_reg[c] <= RCM_RESET_BYTE;
					smp_reg[c] <= '0;
				end
				else
				begin
					if (wr_limh[c])
						limh_reg[c] <= reg_wdata;
					if (wr_liml[c])
						liml_reg[c] <= reg_wdata & RCM_LIML_WMASK;
					if (wr_smp[c])
						smp_reg[c] <= reg_wdata[3:0];
				end
			end

			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
				begin
					cnt_reg <= '0;
					first_reg <= '0;
					ext_reg <= '0;
					dir_reg <= RCM_DIR_NONE;
					par_reg <= 1'b0;
					chg_reg <= 1'b0;
					shown_chg_reg <= 1'b0;
					shown_odd_reg <= 1'b0;
					res_reg <= '0;
				end
				else if (!enable)
					cnt_reg <= '0;
				else if (hit && cnt_reg == 9'h000)
				begin
					cnt_reg <= 9'h001;
					first_reg <= ts;
					ext_reg <= ts;
					dir_reg <= RCM_DIR_NONE;
					par_reg <= 1'b0;
					chg_reg <= 1'b0;
				end
				else if (hit)
				begin
					cnt_reg <= done_w[c] ? 9'h000 : 9'(cnt_reg + 9'h001);
					if (rev || (dir_reg == RCM_DIR_NONE && (rise || fall)))
					begin
						dir_reg <= rise ? RCM_DIR_UP : RCM_DIR_DOWN;
						ext_reg <= ts;
					end
					else if ((dir_reg == RCM_DIR_UP && $signed(ts) > $signed(ext_reg)) ||
						(dir_reg == RCM_DIR_DOWN && $signed(ts) < $signed(ext_reg)))
						ext_reg <= ts;
					par_reg <= par_reg ^ rev;
					chg_reg <= chg_reg | rev;
					if (done_w[c])
					begin
						res_reg <= sat;
						shown_chg_reg <= chg_reg | rev;
						shown_odd_reg <= par_reg ^ rev;
					end
				end
			end
		end
	endgenerate

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_DISABLED_FROZEN: assert property (!enable |=> $stable(res_w))
		else $error("result changed while disabled");
	AST_CH2_ALERT: assert property ((hi_reg[1] | lo_reg[1]) & !config_reg[RCM_CFG_MASK2] |-> rate_alert)
		else $error("channel 2 event missed alert");
	AST_CH1_ALERT: assert property ((hi_reg[0] | lo_reg[0]) & !config_reg[RCM_CFG_CHAN1_RATE_ALERT_MASK] |-> rate_alert)
		else $error("channel 1 event missed alert");
	AST_MASKED_QUIET: assert property (config_reg[RCM_CFG_CHAN1_RATE_ALERT_MASK] & config_reg[RCM_CFG_MASK2] |-> !rate_alert)
		else $error("alert with both masks set");
	AST_HI_READ_CLEAR: assert property (rd_stat & !hi_set[0] |=> !hi_reg[0])
		else $error("high flag survived status read");
	AST_LO_NEG_ONLY: assert property ($rose(lo_reg[1]) |-> $past(lim_w[1][11]))
		else $error("low flag with positive limit");
	AST_RES1_READ: assert property (reg_rd & reg_addr == RCM_ADDR_RES1H |=> reg_rdata == $past(res_w[0][11:4]))
		else $error("wrong channel 1 result byte");
	AST_RESL_READ: assert property (reg_rd & reg_addr == RCM_ADDR_RESL |=>
		reg_rdata == {$past(res_w[1][3:0]), $past(res_w[0][3:0])})
		else $error("wrong packed low nibbles");
	AST_LIM2_WRITE: assert property (wr_limh[1] |=> limh_reg[1] == $past(reg_wdata))
		else $error("channel 2 limit not stored");
	AST_LIM1_WRITE: assert property (wr_limh[0] |=> limh_reg[0] == $past(reg_wdata))
		else $error("channel 1 limit not stored");
	AST_LO_READ_CLEAR: assert property (rd_stat & !lo_set[1] |=> !lo_reg[1])
		else $error("low flag survived status read");
	AST_HI_SET_WINS: assert property (hi_set[1] |=> hi_reg[1])
		else $error("high flag lost to read clear");
	AST_LO_SET_WINS: assert property (lo_set[0] |=> lo_reg[0])
		else $error("low flag lost to read clear");
	AST_HI_POS_ONLY: assert property ($rose(hi_reg[0]) |-> !$past(lim_w[0][11]))
		else $error("high flag with negative limit");
	AST_NO_SET_DISABLED: assert property (!enable |-> (hi_set == 2'b00) && (lo_set == 2'b00))
		else $error("flag set while disabled");
	AST_RES2_READ: assert property (reg_rd & reg_addr == RCM_ADDR_RES2H |=> reg_rdata == $past(res_w[1][11:4]))
		else $error("wrong channel 2 result byte");
	AST_STATUS_READ: assert property (reg_rd & reg_addr == RCM_ADDR_STATUS |=> reg_rdata == $past(status_w))
		else $error("wrong status byte");
	AST_LIML_MASK: assert property (wr_liml[0] |=> liml_reg[0] == ($past(reg_wdata) & RCM_LIML_WMASK))
		else $error("low limit nibble not stored");
	AST_CH2_MASKED: assert property (config_reg[RCM_CFG_MASK2] & !(hi_reg[0] | lo_reg[0]) |-> !rate_alert)
		else $error("masked channel 2 raised alert");
	AST_CH1_MASKED: assert property (config_reg[RCM_CFG_CHAN1_RATE_ALERT_MASK] & !(hi_reg[1] | lo_reg[1]) |-> !rate_alert)
		else $error("masked channel 1 raised alert");
	AST_GAIN_WRITE: assert property (wr_gain |=> gain_reg == $past(reg_wdata))
		else $error("gain not stored");
	AST_CFG_WRITE: assert property (wr_cfg |=> config_reg == ($past(reg_wdata) & RCM_CFG_WMASK))
		else $error("config not stored");
	AST_SMP_WRITE: assert property (wr_smp[1] |=> smp_reg[1] == $past(reg_wdata[3:0]))
		else $error("sample code not stored");

	COV_HI1: cover property (hi_set[0]);
	COV_LO2: cover property (lo_set[1]);
	COV_REV: cover property (done_w[0] & g_chan[0].rev);
	COV_CLEAR_RACE: cover property (rd_stat & hi_set[1]);
	COV_LONG_WINDOW: cover property (done_w[0] & (|smp_reg[0]));
endmodule
`default_nettype wire

// ---- rcm_host_model.sv ----
// register host model driving the rate monitor's register port
`timescale 1ns/100ps
`default_nettype none
module rcm_host_model (
	input wire logic sys_clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ---- temp_rate_of_change_monitor_test.sv ----
// self-checking bench for the rate-of-change monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module temp_rate_of_change_monitor_test;
	import rcm_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, rate_alert;
	logic temp_valid = 1'b0;
	logic temp_chan = 1'b0;
	logic [10:0] temp_value = 11'h000;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	always #5 sys_clk = ~sys_clk;
	rcm_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	rcm_top dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_valid(temp_valid), .temp_chan(temp_chan),
		.temp_value(temp_value), .rate_alert(rate_alert));
	task automatic report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			report_and_stop();
		end
	end
	// difference times two to the gain code, saturated
	function automatic logic [11:0] exp_rate(input int d, input int g);
		int r;
		r = d * (1 << g);
		if (r > 2047)
			r = 2047;
		if (r < -2048)
			r = -2048;
		return 12'(r);
	endfunction
	task automatic smp(input logic ch, input int v);
		@(posedge sys_clk);
		#1;
		temp_valid = 1'b1;
		temp_chan = ch;
		temp_value = 11'(v);
		@(posedge sys_clk);
		#1;
		temp_valid = 1'b0;
		temp_value = ~temp_value;
	endtask
	initial
	begin
		logic [7:0] adr [9];
		logic [7:0] rv, lh, ll, msk, st;
		logic [11:0] r;
		logic ch, hi, lo;
		int g, d, t0, lim;
		int win [3][5] = '{'{0, 20, 30, 25, 10}, '{0, 20, 5, 20, 30}, '{0, 20, 30, 25, 28}};
		logic [7:0] exp_st [3] = '{8'h50, 8'h40, 8'h00};
		adr = '{RCM_ADDR_GAIN, RCM_ADDR_CONFIG, RCM_ADDR_STATUS, RCM_ADDR_RES1H, RCM_ADDR_LIM1H,
			RCM_ADDR_RES2H, RCM_ADDR_RESL, RCM_ADDR_LIM2H, 8'h60};
		void'($urandom(33));
		repeat (8) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		foreach (adr[i])
		begin
			host.rd(adr[i], rv);
			`CHK("reset value", 8'h00, rv)
		end
		host.wr(RCM_ADDR_CONFIG, 8'hFF);
		host.rd(RCM_ADDR_CONFIG, rv);
		`CHK("config", 8'h3F, rv)
		host.wr(8'h60, 8'hAA);
		host.rd(8'h60, rv);
		`CHK("unmapped", 8'h00, rv)
		for (int i = 0; i < 24; i++)
		begin
			ch = 1'($urandom % 2);
			g = $urandom % 8;
			d = int'($urandom % 401) - 200;
			t0 = $urandom % 500;
			lh = ($urandom % 2) ? 8'($urandom % 4) : (8'hFC | 8'($urandom % 4));
			ll = 8'($urandom % 16) << 4;
			msk = 8'($urandom % 2) << (ch ? 4 : 3);
			host.wr(RCM_ADDR_GAIN, 8'(g * 9));
			host.wr(ch ? RCM_ADDR_LIM2H : RCM_ADDR_LIM1H, lh);
			host.wr(ch ? RCM_ADDR_LIM2L : RCM_ADDR_LIM1L, ll);
			host.wr(RCM_ADDR_CONFIG, 8'h20 | msk);
			smp(ch, t0);
			smp(ch, t0 + d);
			r = exp_rate(d, g);
			lim = int'($signed({lh, ll[7:4]}));
			hi = (lim >= 0) && (int'($signed(r)) > lim);
			lo = (lim < 0) && (int'($signed(r)) < lim);
			`CHK("alert", 1'((hi | lo) & (msk == 8'h00)), rate_alert)
			host.rd(RCM_ADDR_STATUS, st);
			`CHK("status", {4'h0, hi & ch, hi & ~ch, lo & ch, lo & ~ch}, st)
			host.rd(RCM_ADDR_STATUS, st);
			`CHK("status cleared", 8'h00, st)
			`CHK("alert cleared", 1'b0, rate_alert)
			host.rd(ch ? RCM_ADDR_RES2H : RCM_ADDR_RES1H, rv);
			`CHK("result high", r[11:4], rv)
			host.rd(RCM_ADDR_RESL, rv);
			`CHK("result low", r[3:0], ch ? rv[7:4] : rv[3:0])
		end
		host.wr(RCM_ADDR_CONFIG, 8'h00);
		smp(ch, 0);
		smp(ch, 900);
		host.rd(ch ? RCM_ADDR_RES2H : RCM_ADDR_RES1H, rv);
		`CHK("frozen result", r[11:4], rv)
		host.rd(RCM_ADDR_STATUS, st);
		`CHK("frozen status", 8'h00, st)
		// five-sample windows on channel 1, hysteresis 1 degC
		host.wr(RCM_ADDR_SMP1, 8'hF2);
		host.rd(RCM_ADDR_SMP1, rv);
		`CHK("sample code", 8'h02, rv)
		host.wr(RCM_ADDR_LIM1H, 8'h7F);
		host.wr(RCM_ADDR_LIM1L, 8'hFF);
		host.rd(RCM_ADDR_LIM1L, rv);
		`CHK("low limit", 8'hF0, rv)
		host.wr(RCM_ADDR_GAIN, 8'h00);
		host.wr(RCM_ADDR_CONFIG, 8'h24);
		for (int w = 0; w < 3; w++)
		begin
			for (int k = 0; k < 5; k++)
				smp(1'b0, win[w][k]);
			r = exp_rate(win[w][4] - win[w][0], 0);
			host.rd(RCM_ADDR_STATUS, st);
			`CHK("window status", exp_st[w], st)
			host.rd(RCM_ADDR_RES1H, rv);
			`CHK("window high", r[11:4], rv)
			host.rd(RCM_ADDR_RESL, rv);
			`CHK("window low", r[3:0], rv[3:0])
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
